// ==== design/bli_defines.svh ====
// Constants for the bit and logic instruction execution block.
// Assumes a 12-bit instruction word and a 32-entry file register space.
//
// Contract
// - Any program counter write except the unconditional branch forces counter bit 8 low.
// - Read-modify-write of the I/O port takes its source value from the pins.
// - Direction load with operand 6 copies W to second port direction latches.
// - Timer count register targeted with d=1 clears prescaler when assigned to timer.
// - Add sums W and file register, updating carry, digit carry and zero.
// - Destination bit 0 writes W, 1 writes the addressed file register.
// - Bit clear clears the selected bit, flags untouched.
// - Bit set sets the selected bit, flags untouched.
// - AND literal ANDs W with eight-bit literal into W, zero flag only.
// - AND register ANDs W with file register, routed by d, zero flag only.
// - Skip-if-clear skips the next instruction when the bit reads zero.
// - Skip-if-set skips the next instruction when the bit reads one.
// - A taken skip replaces the prefetched instruction with a no-operation.
// - One instruction cycle lasts four clocks; instructions that neither skip nor write the program counter take one.
// - Opcodes 0100/0101/0110/0111 are clear/set/skip-clear/skip-set; then bit, register.
`ifndef BLI_DEFINES_SVH
`define BLI_DEFINES_SVH

`define BLI_CLK_PER_CYC 3'h4
`define BLI_OP_BCLR 4'h4
`define BLI_OP_BSET 4'h5
`define BLI_OP_SKPC 4'h6
`define BLI_OP_SKPS 4'h7
`define BLI_OP_REG 4'h1
`define BLI_OP_ANDL 4'hE
`define BLI_SUB_ADD 2'h3
`define BLI_SUB_AND 2'h1
`define BLI_NOP 12'h000
`define BLI_DIR_LOAD 12'h006
`define BLI_F_TMR 5'h01
`define BLI_F_PCL 5'h02
`define BLI_F_STAT 5'h03
`define BLI_F_PORT 5'h06
`define BLI_APB_CTRL 8'h00
`define BLI_APB_STATE 8'h04
`define BLI_APB_PC 8'h08
`define BLI_CTRL_RST 2'h0
`define BLI_PC_RST 11'h000
`define BLI_W_RST 8'h00
`define BLI_DIRECTION_LOAD_INSTR_RST 8'hFF

`endif

// ==== design/bli_pkg.sv ====
// Types for the bit and logic instruction execution block.
// Assumes bli_defines.svh for all numeric constants.
package bli_pkg;
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] sub;
        logic d;
        logic [4:0] f;
    } bli_instr_t;

    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } bli_flags_t;

    typedef enum logic [1:0] {
        BLI_Q1,
        BLI_Q2,
        BLI_Q3,
        BLI_Q4
    } bli_phase_t;
endpackage

// ==== design/bli_exec.sv ====
// Execution core for add, AND, bit clear/set and bit test-skip instructions.
// Assumes program memory answers pc_o combinationally on instr_i within a cycle.
`timescale 1ns/1ps
`include "bli_defines.svh"

module bli_exec
    import bli_pkg::*;
(
    input wire logic clk_i, // 200 MHz clock
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic [10:0] pc_o, // Program memory address
    input wire logic [11:0] instr_i, // Program memory word
    input wire logic [7:0] port_pin_i, // Second port pin levels
    output logic [7:0] port_out_o, // Second port output latch
    output logic [7:0] port_oe_n_o, // Second port enable, low drives
    output logic prescaler_clr_o // Prescaler clear pulse
);
    bli_phase_t phase_q;
    bli_instr_t ir_q;
    bli_flags_t flags_q;
    bli_flags_t flags_d;
    logic [10:0] pc_q;
    logic [7:0] w_q;
    logic [7:0] direction_load_instr_q;
    logic [7:0] file_q [32];
    logic [1:0] ctrl_q;
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_s3_q;
    logic [7:0] pin_q;
    logic presc_q;
    logic run;
    logic exec;
    logic [7:0] fval;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [7:0] res_d;
    logic wr_w;
    logic wr_f;
    logic upd_z;
    logic upd_cdc;
    logic skip_d;
    logic direction_load_instr_ld;
    logic presc_hit;
    logic apb_wr;
    logic apb_rd;

    assign run = ctrl_q[0];
    assign exec = run && (phase_q == BLI_Q4);
    assign pc_o = pc_q;
    assign port_out_o = file_q[`BLI_F_PORT];
    assign port_oe_n_o = direction_load_instr_q;
    assign prescaler_clr_o = presc_q;
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    // Three-stage pin synchroniser, accepted once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
            pin_q <= 8'h00;
        end else begin
            pin_s1_q <= port_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_q <= pin_s3_q;
            end
        end
    end

    // Source operand fetch
    always_comb begin
        case (ir_q.f)
            `BLI_F_PCL: fval = pc_q[7:0];
            `BLI_F_STAT: fval = {5'h00, flags_q};
            `BLI_F_PORT: fval = pin_q;
            default: fval = file_q[ir_q.f];
        endcase
    end

    // Decode and execute
    always_comb begin
        logic [2:0] bsel;
        bsel = {ir_q.sub, ir_q.d};
        sum9 = {1'b0, w_q} + {1'b0, fval};
        half5 = {1'b0, w_q[3:0]} + {1'b0, fval[3:0]};
        res_d = 8'h00;
        wr_w = 1'b0;
        wr_f = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        skip_d = 1'b0;
        direction_load_instr_ld = 1'b0;
        case (ir_q.op)
            `BLI_OP_REG: begin
                if (ir_q.sub == `BLI_SUB_ADD) begin
                    res_d = sum9[7:0];
                    upd_z = 1'b1;
                    upd_cdc = 1'b1;
                    wr_w = !ir_q.d;
                    wr_f = ir_q.d;
                end else if (ir_q.sub == `BLI_SUB_AND) begin
                    res_d = w_q & fval;
                    upd_z = 1'b1;
                    wr_w = !ir_q.d;
                    wr_f = ir_q.d;
                end
            end
            `BLI_OP_BCLR: begin
                res_d = fval & ~(8'h01 << bsel);
                wr_f = 1'b1;
            end
            `BLI_OP_BSET: begin
                res_d = fval | (8'h01 << bsel);
                wr_f = 1'b1;
            end
            `BLI_OP_SKPC: skip_d = !fval[bsel];
            `BLI_OP_SKPS: skip_d = fval[bsel];
            `BLI_OP_ANDL: begin
                res_d = w_q & {ir_q.sub, ir_q.d, ir_q.f};
                upd_z = 1'b1;
                wr_w = 1'b1;
            end
            default: direction_load_instr_ld = (ir_q == `BLI_DIR_LOAD);
        endcase
    end

    assign presc_hit = ctrl_q[1] && wr_f && (ir_q.f == `BLI_F_TMR);

    // Flag register write first, the instruction's own flag update wins
    always_comb begin
        flags_d = flags_q;
        if (wr_f && ir_q.f == `BLI_F_STAT) begin
            flags_d = res_d[2:0];
        end
        if (upd_z) begin
            flags_d.z = (res_d == 8'h00);
        end
        if (upd_cdc) begin
            flags_d.c = sum9[8];
            flags_d.dc = half5[4];
        end
    end

    // Instruction cycle of four clocks
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            phase_q <= BLI_Q1;
        end else if (run) begin
            case (phase_q)
                BLI_Q1: phase_q <= BLI_Q2;
                BLI_Q2: phase_q <= BLI_Q3;
                BLI_Q3: phase_q <= BLI_Q4;
                BLI_Q4: phase_q <= BLI_Q1;
                default: phase_q <= BLI_Q1;
            endcase
        end
    end

    // Prefetch and program counter
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ir_q <= `BLI_NOP;
            pc_q <= `BLI_PC_RST;
        end else if (exec) begin
            if (wr_f && ir_q.f == `BLI_F_PCL) begin
                pc_q <= {pc_q[10:9], 1'b0, res_d};
                ir_q <= `BLI_NOP;
            end else begin
                pc_q <= pc_q + 11'h001;
                ir_q <= skip_d ? `BLI_NOP : instr_i;
            end
        end
    end

    // Working register and flags
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            w_q <= `BLI_W_RST;
            flags_q <= 3'h0;
        end else if (exec) begin
            flags_q <= flags_d;
            if (wr_w) begin
                w_q <= res_d;
            end
        end
    end

    // File registers; entry 6 is the port output latch
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 32; i++) begin
                file_q[i] <= 8'h00;
            end
        end else if (exec && wr_f) begin
            file_q[ir_q.f] <= res_d;
        end
    end

    // Direction latches; a one floats the pin
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            direction_load_instr_q <= `BLI_DIRECTION_LOAD_INSTR_RST;
        end else if (exec && direction_load_instr_ld) begin
            direction_load_instr_q <= w_q;
        end
    end

    // One-clock prescaler clear pulse
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            presc_q <= 1'b0;
        end else begin
            presc_q <= exec && presc_hit;
        end
    end

    // APB slave, zero wait states
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_q <= `BLI_CTRL_RST;
        end else if (apb_wr && paddr == `BLI_APB_CTRL) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Register read mux and error answer
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (apb_rd || apb_wr) begin
            case (paddr)
                `BLI_APB_CTRL: prdata = {30'h0000_0000, ctrl_q};
                `BLI_APB_STATE: prdata = {21'h00_0000, flags_q, w_q};
                `BLI_APB_PC: prdata = {21'h00_0000, pc_q};
                default: pslverr = 1'b1;
            endcase
            if (apb_wr) begin
                prdata = 32'h0000_0000;
                pslverr = (paddr != `BLI_APB_CTRL);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Results checked one cycle after the executing edge
    a_pc_bit8_low: assert property (exec && wr_f && ir_q.f == `BLI_F_PCL
        |=> pc_q == {$past(pc_q[10:9]), 1'b0, $past(res_d)} && ir_q == `BLI_NOP)
        else $error("pc bit 8 not cleared");
    a_direction_load_instr_copy: assert property (exec && direction_load_instr_ld |=> direction_load_instr_q == $past(w_q) && port_oe_n_o == direction_load_instr_q)
        else $error("direction latch not loaded");
    a_presc_clear: assert property (exec && presc_hit |=> prescaler_clr_o ##1 !prescaler_clr_o)
        else $error("prescaler clear pulse wrong");
    a_add_flags: assert property (exec && upd_cdc |=> flags_q.c == $past(sum9[8]) && flags_q.dc == $past(half5[4]))
        else $error("add carry flags wrong");
    a_zero_flag: assert property (exec && upd_z |=> flags_q.z == ($past(res_d) == 8'h00))
        else $error("zero flag wrong");
    a_bit_op_flags: assert property (exec && ir_q.op inside {[4'h4:4'h7]} && ir_q.f != `BLI_F_STAT
        |=> $stable(flags_q))
        else $error("bit op touched flags");
    a_w_dest: assert property (exec && wr_w |=> w_q == $past(res_d))
        else $error("W not written");
    a_skip_nop: assert property (exec && skip_d |=> ir_q == `BLI_NOP)
        else $error("skip did not discard prefetch");
    a_cycle_len: assert property (exec && run |=> !exec [*3])
        else $error("instruction cycle shorter than four clocks");
    a_andl_w: assert property (exec && ir_q.op == `BLI_OP_ANDL |=> w_q == ($past(w_q) & $past(ir_q[7:0])))
        else $error("AND literal result wrong");
    a_port_rmw: assert property (exec && ir_q.op == `BLI_OP_BCLR && ir_q.f == `BLI_F_PORT
        |=> port_out_o == ($past(pin_q) & ~(8'h01 << $past(ir_q[7:5]))))
        else $error("port write did not use pin levels");
    a_add_w: assert property (exec && ir_q.op == `BLI_OP_REG && ir_q.sub == `BLI_SUB_ADD && !ir_q.d
        |=> w_q == 8'($past(w_q) + $past(fval)))
        else $error("add result wrong");
    a_and_w: assert property (exec && ir_q.op == `BLI_OP_REG && ir_q.sub == `BLI_SUB_AND && !ir_q.d
        |=> w_q == ($past(w_q) & $past(fval)))
        else $error("AND register result wrong");
    a_bit_set: assert property (exec && ir_q.op == `BLI_OP_BSET && ir_q.f == `BLI_F_TMR
        |=> file_q[`BLI_F_TMR] == ($past(fval) | (8'h01 << $past(ir_q[7:5]))))
        else $error("bit set result wrong");
    a_skip_clear: assert property (exec && ir_q.op == `BLI_OP_SKPC && !fval[ir_q[7:5]] |=> ir_q == `BLI_NOP)
        else $error("skip if clear not taken");
    a_skip_kept: assert property (exec && ir_q.op == `BLI_OP_SKPS && !fval[ir_q[7:5]]
        |=> ir_q == $past(instr_i))
        else $error("skip if set taken on a clear bit");

    c_add_exec: cover property (exec && upd_cdc && flags_d.c);
    c_skip_taken: cover property (exec && skip_d);
    c_port_rmw: cover property (exec && wr_f && ir_q.f == `BLI_F_PORT);
    c_direction_load_instr_load: cover property (exec && direction_load_instr_ld);
    c_pc_write: cover property (exec && wr_f && ir_q.f == `BLI_F_PCL);
endmodule

// ==== bench/bli_prog_mem.sv ====
// Program memory model holding a fixed test program, read combinationally.
// Assumes the core presents pc_i and takes instr_o within the same cycle.
`timescale 1ns/1ps
module bli_prog_mem (
    input wire logic [10:0] pc_i, // Program address
    output logic [11:0] instr_o // Instruction word
);
    logic [11:0] rom [0:20];
    assign instr_o = (pc_i < 11'h015) ? rom[pc_i[4:0]] : 12'h000;
    initial begin
        // Clear W and timer, load pins, set bit, add back to timer
        rom[0:4] = '{12'hE00, 12'h161, 12'h1C6, 12'h561, 12'h1E1};
        // AND literal, AND register, direction load
        rom[5:7] = '{12'hEF0, 12'h141, 12'h006};
        // Skips over bit writes, flags tested through the flag register
        rom[8:15] = '{12'h761, 12'h4E1, 12'h601, 12'h5C1, 12'h603, 12'h5A1, 12'h623, 12'h581};
        // Port bit clear from pins, then W gets the timer
        rom[16:18] = '{12'h406, 12'hE00, 12'h1C1};
        // Jump over a word that would clear W, by setting a bit of the counter
        rom[19:20] = '{12'h502, 12'hE00};
    end
endmodule

// ==== bench/bli_exec_tb_top.sv ====
// Testbench: runs the fixed program for several random pin values.
// Assumes the program memory model and zero-wait APB answers.
`timescale 1ns/1ps
`include "bli_defines.svh"
module bli_exec_tb_top;
    import bli_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prescaler_clr_o;
    logic [10:0] pc_o;
    logic [11:0] instr_i;
    logic [7:0] port_pin_i = 8'h00;
    logic [7:0] port_out_o;
    logic [7:0] port_oe_n_o;
    logic [32:0] exp_q [$];
    int bad_count = 0;
    int n_tests = 0;
    int pulses = 0;
    int seed = 32'h5343;

    always #2.5 clk_i = ~clk_i;

    bli_exec bli_exec_i (.clk_i(clk_i), .nrst_i(nrst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_o(pc_o),
        .instr_i(instr_i), .port_pin_i(port_pin_i), .port_out_o(port_out_o), .port_oe_n_o(port_oe_n_o),
        .prescaler_clr_o(prescaler_clr_o));
    bli_prog_mem bli_prog_mem_i (.pc_i(pc_o), .instr_o(instr_i));

    task automatic check(input logic [32:0] exp, input logic [32:0] act);
        n_tests++;
        if (act !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, act);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the expected error and read data are queued
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
        exp_q.push_back(exp);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Monitor: counts prescaler pulses, compares each APB answer
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            pulses <= 0;
        end else if (prescaler_clr_o === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            check(exp_q.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
        end
    end

    initial begin
        logic [7:0] r;
        logic [7:0] t;
        logic [7:0] w1;
        logic [8:0] s;
        logic [4:0] lo;
        logic presc;
        int np;
        for (int k = 0; k < 6; k++) begin
            r = 8'($random(seed));
            presc = 1'($random(seed));
            if (k == 0) begin
                r = 8'hF8;
            end
            s = {1'b0, r} + 9'h008;
            lo = {1'b0, r[3:0]} + 5'h08;
            t = s[7:0];
            w1 = r & 8'hF0 & t;
            np = presc ? 3 : 0;
            if (!t[3]) begin
                t[7] = 1'b0;
                np = np + presc;
            end
            if (t[0]) begin
                t[6] = 1'b1;
                np = np + presc;
            end
            if (s[8]) begin
                t[5] = 1'b1;
                np = np + presc;
            end
            if (lo[4]) begin
                t[4] = 1'b1;
                np = np + presc;
            end
            @(posedge clk_i);
            nrst_i <= 1'b0;
            port_pin_i <= r;
            repeat (10) @(posedge clk_i);
            nrst_i <= 1'b1;
            apb(1'b1, `BLI_APB_CTRL, {30'h0000_0000, presc, 1'b1}, 33'h0_0000_0000);
            repeat (120) @(posedge clk_i);
            apb(1'b1, `BLI_APB_CTRL, 32'h0000_0000, 33'h0_0000_0000);
            check({25'h000_0000, w1}, {25'h000_0000, port_oe_n_o});
            check({25'h000_0000, r & 8'hFE}, {25'h000_0000, port_out_o});
            check(33'(np), 33'(pulses));
            apb(1'b0, `BLI_APB_STATE, 32'h0000_0000, {22'h00_0000, t == 8'h00, 2'b00, t});
        end
        apb(1'b1, 8'h0C, 32'h0000_0001, {1'b1, 32'h0000_0000});
        apb(1'b1, `BLI_APB_STATE, 32'h0000_0001, {1'b1, 32'h0000_0000});
        repeat (2) @(posedge clk_i);
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
endmodule
